// file: fwpl_pkg.sv
// Constants and types shared by the flash write-protection logic.
// Assumes one 64-block array and a serial link clocked by the host.
package fwpl_pkg;

	// Status byte field positions
	localparam int SR_LOCK_POS = 7;
	localparam int SR_QE_POS = 6;
	localparam int SR_BP_HI = 5;
	localparam int SR_BP_LO = 2;
	localparam int SR_WEL_POS = 1;
	localparam int SR_BUSY_POS = 0;

	// Function byte field positions
	localparam int FR_LOCK_HI = 7;
	localparam int FR_LOCK_LO = 4;
	localparam int FR_ERASE_SUSPENDED_FLAG_POS = 3;
	localparam int FR_PROGRAM_SUSPENDED_FLAG_POS = 2;

	// Reset and initial values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] FUNCTION_RESET = 8'h00;
	localparam logic [3:0] BP_NONE = 4'h0;
	localparam logic [3:0] BP_ALL_LOW = 4'h8;
	localparam logic [3:0] BP_NONE_HIGH = 4'hf;

	// Array geometry, 64 KB blocks
	localparam int BLOCK_LSB = 16;
	localparam int BLOCK_BITS = 6;
	localparam logic [6:0] BLOCK_COUNT = 7'h40;
	localparam int ROW_LSB = 8;

	// Core-side sync depth and least command spacing in core cycles
	localparam int SYNC_STAGES = 2;
	localparam int CMD_SPACING = 4;

	// Commands handed over from the link decoder
	typedef enum logic [3:0] {
		K_NONE,
		K_WRITE_ENABLE_INSTR,
		K_WRDI,
		K_WRITE_STATUS_INSTR,
		K_WRFR,
		K_PROG,
		K_ERASE,
		K_CHIP,
		K_IRP,
		K_SUSP,
		K_RESUME
	} fwpl_kind_e;

endpackage

// file: fwpl_sync.sv
// Two-flop synchroniser for a group of levels.
// Assumes the inputs are stable for several destination clocks.
`timescale 1ns/1ps
module fwpl_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} fwpl_sync_s;

	fwpl_sync_s r;
	fwpl_sync_s n;

	always_comb
	begin
		n.s1 = d;
		n.s2 = r.s1;
		if (reset)
		begin
			n = '0;
		end
	end

	always_ff @(posedge clock)
	begin
		r <= n;
	end

	assign q = r.s2;
endmodule

// file: fwpl_core.sv
// Write protection, status and function bytes of a serial flash.
// Assumes a decoder on the link clock hands over one command at a time,
// spaced by at least four core cycles, and an engine that reports done.
`timescale 1ns/1ps
// Overview of operation
// - Program or erase into protected blocks inhibited
// - Chip erase only with all protect bits zero
// - Lock set, pin low: status writes ignored
// - Lock set, pin high: status writes accepted
// - Lock clear: status always writable
// - Quad enable turns control pins into data
// - Protect code maps 64 KB blocks, edges
// - Codes 0001-0111 protect highest blocks, doubling
// - Codes 1001-1110 protect lowest blocks, halving
// - Function byte: row locks, suspend flags
// - Program suspend sets flag, resume clears
// - Erase suspend sets flag, resume clears
// - Locked information row refuses programming
// - Row lock bits set once only
// - Writes need write enable latch set
// - Low supply ignores every write
// - Protect pin guards code, lock, quad bits
// - Status byte layout lock to busy
// - Write enable clears when operation completes
module fwpl_core (
	// Core clock and control
	input wire logic clock,
	input wire logic reset,
	input wire logic clock_enable,
	// Link side, on the host clock
	input wire logic link_clock,
	input wire logic link_cmd_valid,
	input wire fwpl_pkg::fwpl_kind_e link_cmd_kind,
	input wire logic [23:0] link_cmd_addr,
	input wire logic [7:0] link_cmd_data,
	// Pins
	input wire logic protect_pin_n,
	input wire logic low_supply,
	// Engine
	input wire logic engine_done,
	// Register views
	output logic [7:0] status_byte,
	output logic [7:0] function_byte,
	output logic pins_are_data,
	// Engine requests
	output logic program_start,
	output logic erase_start,
	output logic chip_erase_start,
	output logic row_program_start,
	output logic suspend_request,
	output logic resume_request,
	output logic [23:0] op_addr,
	output logic write_refused
);
	typedef struct packed {
		logic toggle;
		fwpl_pkg::fwpl_kind_e kind;
		logic [23:0] addr;
		logic [7:0] data;
	} fwpl_link_s;

	typedef struct packed {
		logic status_lock_bit;
		logic quad_enable_bit;
		logic [3:0] protect_code;
		logic [3:0] row_lock;
		logic toggle_seen;
		logic write_enable_latch;
		logic busy_flag;
		logic op_erase;
		logic program_suspended_flag;
		logic erase_suspended_flag;
		logic program_start;
		logic erase_start;
		logic chip_erase_start;
		logic row_program_start;
		logic suspend_request;
		logic resume_request;
		logic write_refused;
		logic [23:0] op_addr;
	} fwpl_core_s;

	fwpl_link_s l_reg;
	fwpl_link_s l_next;
	fwpl_core_s c_reg = '0;
	fwpl_core_s c_next;
	logic link_reset;
	logic [2:0] sync_q;
	logic toggle_s;
	logic wp_pin_low;
	logic low_s;
	logic cmd_new;
	logic write_ok;
	logic status_locked;
	logic target_protected;
	logic [5:0] block;
	logic [1:0] row;

	// Link domain: capture a command and flip the toggle
	fwpl_sync #(.W(1)) u_link_reset (
		.clock(link_clock),
		.reset(1'b0),
		.d(reset),
		.q(link_reset)
	);

	always_comb
	begin
		l_next = l_reg;
		if (link_cmd_valid)
		begin
			l_next.toggle = ~l_reg.toggle;
			l_next.kind = link_cmd_kind;
			l_next.addr = link_cmd_addr;
			l_next.data = link_cmd_data;
		end
		if (link_reset)
			l_next = '0;
	end

	always_ff @(posedge link_clock)
		l_reg <= l_next;

	// Pins and toggle into the core domain
	fwpl_sync #(.W(3)) u_core_sync (
		.clock(clock),
		.reset(reset),
		.d({l_reg.toggle, protect_pin_n, low_supply}),
		.q(sync_q)
	);

	assign toggle_s = sync_q[2];
	assign low_s = sync_q[0];
	assign wp_pin_low = ~c_reg.quad_enable_bit & ~sync_q[1];
	assign cmd_new = toggle_s != c_reg.toggle_seen;
	assign write_ok = c_reg.write_enable_latch & ~low_s;
	assign status_locked = c_reg.status_lock_bit & wp_pin_low;
	assign block = l_reg.addr[fwpl_pkg::BLOCK_LSB +: fwpl_pkg::BLOCK_BITS];
	assign row = l_reg.addr[fwpl_pkg::ROW_LSB +: 2];

	// Protected block decode
	function automatic logic block_protected(input logic [3:0] code, input logic [5:0] blk);
		logic [6:0] count;
		count = 7'(fwpl_pkg::BLOCK_COUNT >> code[2:0]);
		if (!code[3])
			count = 7'(7'h01 << (code[2:0] - 3'h1));
		if (code == fwpl_pkg::BP_NONE || code == fwpl_pkg::BP_NONE_HIGH)
			count = '0;
		if (code == fwpl_pkg::BP_ALL_LOW)
			count = fwpl_pkg::BLOCK_COUNT;
		if (!code[3])
			return {1'b0, blk} >= 7'(fwpl_pkg::BLOCK_COUNT - count);
		return {1'b0, blk} < count;
	endfunction

	assign target_protected = block_protected(c_reg.protect_code, block);

	// Core state update
	always_comb
	begin
		c_next = c_reg;
		c_next.program_start = 1'b0;
		c_next.erase_start = 1'b0;
		c_next.chip_erase_start = 1'b0;
		c_next.row_program_start = 1'b0;
		c_next.suspend_request = 1'b0;
		c_next.resume_request = 1'b0;
		c_next.write_refused = 1'b0;
		if (!clock_enable)
			c_next = c_reg;
		else
		begin
			if (engine_done && c_reg.busy_flag)
			begin
				c_next.busy_flag = 1'b0;
				c_next.write_enable_latch = 1'b0;
			end
			if (cmd_new)
			begin
				c_next.toggle_seen = toggle_s;
				case (l_reg.kind)
					fwpl_pkg::K_WRITE_ENABLE_INSTR:
					begin
						if (!low_s)
						begin
							c_next.write_enable_latch = 1'b1;
						end
					end
					fwpl_pkg::K_WRDI:
						c_next.write_enable_latch = 1'b0;
					fwpl_pkg::K_WRITE_STATUS_INSTR:
					begin
						if (!write_ok || c_reg.busy_flag || status_locked)
							c_next.write_refused = 1'b1;
						else
						begin
							c_next.status_lock_bit = l_reg.data[fwpl_pkg::SR_LOCK_POS];
							c_next.quad_enable_bit = l_reg.data[fwpl_pkg::SR_QE_POS];
							c_next.protect_code = l_reg.data[fwpl_pkg::SR_BP_HI:fwpl_pkg::SR_BP_LO];
							c_next.write_enable_latch = 1'b0;
						end
					end
					fwpl_pkg::K_WRFR:
					begin
						if (!write_ok || c_reg.busy_flag)
							c_next.write_refused = 1'b1;
						else
						begin
							c_next.row_lock = c_reg.row_lock | l_reg.data[fwpl_pkg::FR_LOCK_HI:fwpl_pkg::FR_LOCK_LO];
							c_next.write_enable_latch = 1'b0;
						end
					end
					fwpl_pkg::K_PROG, fwpl_pkg::K_ERASE, fwpl_pkg::K_CHIP, fwpl_pkg::K_IRP:
					begin
						if (!write_ok || c_reg.busy_flag || c_reg.program_suspended_flag
							|| c_reg.erase_suspended_flag
							|| (l_reg.kind == fwpl_pkg::K_CHIP && c_reg.protect_code != fwpl_pkg::BP_NONE)
							|| ((l_reg.kind == fwpl_pkg::K_PROG || l_reg.kind == fwpl_pkg::K_ERASE)
							&& target_protected)
							|| (l_reg.kind == fwpl_pkg::K_IRP && c_reg.row_lock[row]))
							c_next.write_refused = 1'b1;
						else
						begin
							c_next.busy_flag = 1'b1;
							c_next.op_erase = l_reg.kind == fwpl_pkg::K_ERASE || l_reg.kind == fwpl_pkg::K_CHIP;
							c_next.op_addr = l_reg.addr;
							c_next.program_start = l_reg.kind == fwpl_pkg::K_PROG;
							c_next.erase_start = l_reg.kind == fwpl_pkg::K_ERASE;
							c_next.chip_erase_start = l_reg.kind == fwpl_pkg::K_CHIP;
							c_next.row_program_start = l_reg.kind == fwpl_pkg::K_IRP;
						end
					end
					fwpl_pkg::K_SUSP:
					begin
						if (c_reg.busy_flag && !engine_done)
						begin
							c_next.busy_flag = 1'b0;
							c_next.suspend_request = 1'b1;
							c_next.erase_suspended_flag = c_reg.op_erase;
							c_next.program_suspended_flag = ~c_reg.op_erase;
						end
					end
					fwpl_pkg::K_RESUME:
					begin
						if (c_reg.program_suspended_flag || c_reg.erase_suspended_flag)
						begin
							c_next.busy_flag = 1'b1;
							c_next.resume_request = 1'b1;
							c_next.program_suspended_flag = 1'b0;
							c_next.erase_suspended_flag = 1'b0;
						end
					end
					default:
					begin
						c_next.toggle_seen = toggle_s;
					end
				endcase
			end
		end
		if (reset)
		begin
			c_next = '0;
			c_next.status_lock_bit = c_reg.status_lock_bit;
			c_next.quad_enable_bit = c_reg.quad_enable_bit;
			c_next.protect_code = c_reg.protect_code;
			c_next.row_lock = c_reg.row_lock;
		end
	end

	always_ff @(posedge clock)
		c_reg <= c_next;

	// Register views and requests
	assign status_byte = {c_reg.status_lock_bit, c_reg.quad_enable_bit, c_reg.protect_code,
		c_reg.write_enable_latch, c_reg.busy_flag};
	assign function_byte = {c_reg.row_lock, c_reg.erase_suspended_flag, c_reg.program_suspended_flag, 2'h0};
	assign pins_are_data = c_reg.quad_enable_bit;
	assign program_start = c_reg.program_start;
	assign erase_start = c_reg.erase_start;
	assign chip_erase_start = c_reg.chip_erase_start;
	assign row_program_start = c_reg.row_program_start;
	assign suspend_request = c_reg.suspend_request;
	assign resume_request = c_reg.resume_request;
	assign op_addr = c_reg.op_addr;
	assign write_refused = c_reg.write_refused;

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	logic cmd_go;
	logic is_write_kind;
	assign cmd_go = cmd_new && clock_enable;
	assign is_write_kind = l_reg.kind inside {fwpl_pkg::K_PROG, fwpl_pkg::K_ERASE, fwpl_pkg::K_CHIP,
		fwpl_pkg::K_IRP, fwpl_pkg::K_WRITE_STATUS_INSTR, fwpl_pkg::K_WRFR};

	sequence s_prog_suspend;
		cmd_go && l_reg.kind == fwpl_pkg::K_SUSP && c_reg.busy_flag && !engine_done && !c_reg.op_erase;
	endsequence

	sequence s_erase_resume;
		cmd_go && l_reg.kind == fwpl_pkg::K_RESUME && c_reg.erase_suspended_flag;
	endsequence

	a_wel_gate: assert property (cmd_go && is_write_kind && !c_reg.write_enable_latch
		|=> write_refused && !program_start && !erase_start && !chip_erase_start)
		else $error("write accepted without write enable");
	a_chip_guard: assert property (cmd_go && l_reg.kind == fwpl_pkg::K_CHIP && c_reg.protect_code != 4'h0
		|=> !chip_erase_start && write_refused)
		else $error("chip erase started with protect code set");
	a_block_guard: assert property (cmd_go && l_reg.kind == fwpl_pkg::K_PROG && target_protected
		|=> !program_start ##1 !program_start)
		else $error("program into protected block");
	a_status_lock: assert property (cmd_go && l_reg.kind == fwpl_pkg::K_WRITE_STATUS_INSTR && status_locked
		|=> $stable(status_byte[7:2]))
		else $error("locked status byte changed");
	a_status_write: assert property (cmd_go && l_reg.kind == fwpl_pkg::K_WRITE_STATUS_INSTR && write_ok && !c_reg.busy_flag
		&& !status_locked |=> status_byte[7:2] == $past(l_reg.data[7:2]) && !status_byte[1])
		else $error("status write not applied");
	a_lock_sticky: assert property (1'b1 |=> (c_reg.row_lock & $past(c_reg.row_lock)) == $past(c_reg.row_lock))
		else $error("row lock bit cleared");
	a_prog_suspend: assert property (s_prog_suspend |=> function_byte[2] && !status_byte[0] && suspend_request)
		else $error("program suspend flag not set");
	a_erase_resume: assert property (s_erase_resume |=> !function_byte[3] && status_byte[0] && resume_request)
		else $error("erase resume did not clear flag");
	a_wel_clear: assert property (clock_enable && engine_done && c_reg.busy_flag
		&& !(cmd_go && l_reg.kind == fwpl_pkg::K_WRITE_ENABLE_INSTR) |=> !status_byte[1])
		else $error("write enable kept after completion");
	a_low_supply: assert property (cmd_go && low_s && l_reg.kind == fwpl_pkg::K_WRITE_ENABLE_INSTR
		|=> $stable(status_byte[1]))
		else $error("write enable set under low supply");
	a_row_lock: assert property (cmd_go && l_reg.kind == fwpl_pkg::K_IRP && c_reg.row_lock[row]
		|=> !row_program_start && write_refused)
		else $error("locked row programmed");
endmodule

// file: fwpl_host_model.sv
// Host-side model that hands decoded commands to the link side.
// Assumes the caller spaces commands; the link clock runs only in frames.
`timescale 1ns/1ps
module fwpl_host_model (
	// Link outputs
	output logic link_clock,
	output logic link_cmd_valid,
	output fwpl_pkg::fwpl_kind_e link_cmd_kind,
	output logic [23:0] link_cmd_addr,
	output logic [7:0] link_cmd_data
);
	initial
	begin
		link_clock = 1'b0;
		link_cmd_valid = 1'b0;
		link_cmd_kind = fwpl_pkg::K_NONE;
		link_cmd_addr = 24'h000000;
		link_cmd_data = 8'h00;
	end

	// Idle link clock edges, used around reset
	task automatic edges(input int n);
		repeat (n)
		begin
			#40 link_clock = 1'b1;
			#40 link_clock = 1'b0;
		end
	endtask

	// One command word, held until taken, then shown inverted
	task automatic send(input fwpl_pkg::fwpl_kind_e k, input logic [23:0] a, input logic [7:0] d);
		#7;
		link_cmd_kind = k;
		link_cmd_addr = a;
		link_cmd_data = d;
		link_cmd_valid = 1'b1;
		#33 link_clock = 1'b1;
		#40 link_clock = 1'b0;
		link_cmd_valid = 1'b0;
		link_cmd_kind = fwpl_pkg::fwpl_kind_e'(~k);
		link_cmd_addr = ~a;
		link_cmd_data = ~d;
	endtask
endmodule

// file: flash_write_protection_logic_tb_top.sv
// Self-checking bench for the flash write-protection core.
// Assumes the host model drives the link side and the bench plays the engine.
`timescale 1ns/1ps
module flash_write_protection_logic_tb_top;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic protect_pin_n = 1'b1;
	logic low_supply = 1'b0;
	logic engine_done = 1'b0;
	logic link_clock, link_cmd_valid;
	fwpl_pkg::fwpl_kind_e link_cmd_kind;
	logic [23:0] link_cmd_addr, op_addr;
	logic [7:0] link_cmd_data, status_byte, function_byte;
	logic pins_are_data, program_start, erase_start, chip_erase_start, row_program_start;
	logic suspend_request, resume_request, write_refused;
	logic clock_enable = 1'b1;
	logic st, rf;
	logic [1:0] sp;
	logic [3:0] sv;
	int errors = 0;
	int num_checks = 0;

	always #12.5 clock = ~clock;

	fwpl_host_model host (
		.link_clock(link_clock), .link_cmd_valid(link_cmd_valid), .link_cmd_kind(link_cmd_kind),
		.link_cmd_addr(link_cmd_addr), .link_cmd_data(link_cmd_data)
	);

	fwpl_core dut_u (
		.clock(clock), .reset(reset), .clock_enable(clock_enable), .link_clock(link_clock),
		.link_cmd_valid(link_cmd_valid), .link_cmd_kind(link_cmd_kind), .link_cmd_addr(link_cmd_addr),
		.link_cmd_data(link_cmd_data), .protect_pin_n(protect_pin_n), .low_supply(low_supply),
		.engine_done(engine_done), .status_byte(status_byte), .function_byte(function_byte),
		.pins_are_data(pins_are_data), .program_start(program_start), .erase_start(erase_start),
		.chip_erase_start(chip_erase_start), .row_program_start(row_program_start),
		.suspend_request(suspend_request), .resume_request(resume_request), .op_addr(op_addr),
		.write_refused(write_refused)
	);

	task automatic conclude;
		if (errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		num_checks++;
		if (g !== e)
		begin
			$display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
			errors++;
		end
	endtask

	// Reset held 17 cycles, with link edges so the link side clears too
	task automatic do_reset;
		@(posedge clock) reset <= 1'b1;
		fork
			repeat (16) @(posedge clock);
			host.edges(3);
		join
		@(posedge clock) reset <= 1'b0;
		host.edges(3);
	endtask

	// Sends one command and gathers the pulses that answer it
	task automatic run(input fwpl_pkg::fwpl_kind_e k, input logic [23:0] a, input logic [7:0] d);
		st = 1'b0;
		rf = 1'b0;
		sp = 2'b00;
		sv = 4'h0;
		host.send(k, a, d);
		repeat (8) @(negedge clock)
		begin
			st |= program_start | erase_start | chip_erase_start | row_program_start;
			sv |= {program_start, erase_start, chip_erase_start, row_program_start};
			rf |= write_refused;
			sp |= {suspend_request, resume_request};
		end
	endtask

	task automatic write_enable_instr;
		run(fwpl_pkg::K_WRITE_ENABLE_INSTR, 24'h000000, 8'h00);
		chk(status_byte[1], 1, "write enable latch");
	endtask

	task automatic op(input fwpl_pkg::fwpl_kind_e k, input logic [23:0] a, input logic exp);
		logic [3:0] want;
		want = {k == fwpl_pkg::K_PROG, k == fwpl_pkg::K_ERASE, k == fwpl_pkg::K_CHIP, k == fwpl_pkg::K_IRP} & {4{exp}};
		run(k, a, 8'h00);
		chk(st, exp, "start pulse");
		chk(sv, want, "start pulse kind");
		chk(rf, !exp, "refused pulse");
		if (st)
			chk(op_addr, a, "operation address");
	endtask

	task automatic finish_op;
		@(posedge clock) engine_done <= 1'b1;
		@(posedge clock) engine_done <= 1'b0;
		repeat (2) @(negedge clock);
		chk(status_byte[1:0], 0, "busy and latch after done");
	endtask

	task automatic write_status_instr(input logic [7:0] d);
		write_enable_instr;
		run(fwpl_pkg::K_WRITE_STATUS_INSTR, 24'h000000, d);
	endtask

	function automatic logic prot(input logic [3:0] c, input int b);
		if (c == 4'h0 || c == 4'hf)
			return 1'b0;
		if (c == 4'h8)
			return 1'b1;
		if (!c[3])
			return b >= 64 - (1 << (c - 1));
		return b < (64 >> (c - 8));
	endfunction

	task automatic test_protect_codes;
		for (int c = 0; c < 16; c++)
		begin
			write_status_instr({2'b00, c[3:0], 2'b00});
			chk(status_byte, {2'b00, c[3:0], 2'b00}, "status after write");
			for (int b = 0; b < 64; b++)
			begin
				write_enable_instr;
				op(b[0] ? fwpl_pkg::K_ERASE : fwpl_pkg::K_PROG, {2'b00, b[5:0], 16'h0123}, !prot(c[3:0], b));
				if (st)
					finish_op;
			end
			write_enable_instr;
			op(fwpl_pkg::K_CHIP, 24'h000000, c == 0);
			if (st)
				finish_op;
		end
	endtask

	task automatic test_status_lock;
		@(posedge clock) protect_pin_n <= 1'b0;
		repeat (4) @(posedge clock);
		write_status_instr(8'h04);
		chk(status_byte, 8'h04, "unlocked write, pin low");
		write_status_instr(8'h80);
		write_status_instr(8'h00);
		chk(rf, 1, "locked write refused");
		chk(status_byte, 8'h82, "locked status kept");
		@(posedge clock) protect_pin_n <= 1'b1;
		repeat (4) @(posedge clock);
		write_status_instr(8'h40);
		chk(status_byte, 8'h40, "locked write, pin high");
		chk(pins_are_data, 1, "pins as data");
		write_status_instr(8'h00);
		chk(pins_are_data, 0, "pins as control");
	endtask

	task automatic test_suspend;
		for (int i = 0; i < 2; i++)
		begin
			write_enable_instr;
			op(i == 0 ? fwpl_pkg::K_PROG : fwpl_pkg::K_ERASE, 24'h050000, 1'b1);
			run(fwpl_pkg::K_SUSP, 24'h000000, 8'h00);
			chk(sp, 2'b10, "suspend pulse");
			chk(function_byte, i == 0 ? 8'h04 : 8'h08, "suspended flag set");
			chk(status_byte[0], 0, "idle while suspended");
			run(fwpl_pkg::K_RESUME, 24'h000000, 8'h00);
			chk(sp, 2'b01, "resume pulse");
			chk(function_byte, 8'h00, "suspended flag clear");
			chk(status_byte[0], 1, "busy after resume");
			finish_op;
		end
		run(fwpl_pkg::K_SUSP, 24'h000000, 8'h00);
		chk(sp, 2'b00, "suspend while idle");
		chk(function_byte, 8'h00, "no flag while idle");
	endtask

	task automatic test_rows;
		write_enable_instr;
		run(fwpl_pkg::K_WRFR, 24'h000000, 8'h20);
		chk(function_byte, 8'h20, "row lock set");
		write_enable_instr;
		op(fwpl_pkg::K_IRP, 24'h000100, 1'b0);
		write_enable_instr;
		op(fwpl_pkg::K_IRP, 24'h000000, 1'b1);
		finish_op;
		write_enable_instr;
		run(fwpl_pkg::K_WRFR, 24'h000000, 8'h00);
		chk(function_byte, 8'h20, "row lock kept");
	endtask

	task automatic test_low_supply;
		run(fwpl_pkg::K_PROG, 24'h000000, 8'h00);
		chk(rf, 1, "program without latch");
		@(posedge clock) low_supply <= 1'b1;
		repeat (4) @(posedge clock);
		run(fwpl_pkg::K_WRITE_ENABLE_INSTR, 24'h000000, 8'h00);
		chk(status_byte[1], 0, "enable under low supply");
		@(posedge clock) low_supply <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	// Command taken while frozen runs once the enable returns
	task automatic test_freeze;
		@(posedge clock) clock_enable <= 1'b0;
		run(fwpl_pkg::K_WRITE_ENABLE_INSTR, 24'h000000, 8'h00);
		chk(status_byte[1], 0, "latch held while frozen");
		@(posedge clock) clock_enable <= 1'b1;
		repeat (2) @(negedge clock);
		chk(status_byte[1], 1, "latch set after thaw");
		run(fwpl_pkg::K_WRDI, 24'h000000, 8'h00);
		chk(status_byte[1], 0, "write disable");
	endtask

	initial
	begin
		do_reset;
		chk(status_byte, 8'h00, "status initial");
		chk(function_byte, 8'h00, "function initial");
		test_freeze;
		test_low_supply;
		test_status_lock;
		test_suspend;
		test_rows;
		test_protect_codes;
		write_status_instr(8'h28);
		do_reset;
		chk(status_byte, 8'h28, "status kept over reset");
		chk(function_byte, 8'h20, "function kept over reset");
		conclude;
	end

	initial
	begin
		#2000000;
		errors++;
		conclude;
	end
endmodule
